// file: gpio_consts.svh
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define GPIO_OFS_DIR      8'h00
`define GPIO_OFS_DIRSET   8'h04
`define GPIO_OFS_DIRCLR   8'h08
`define GPIO_OFS_DIRTGL   8'h0c
`define GPIO_OFS_OUT      8'h10
`define GPIO_OFS_OUTSET   8'h14
`define GPIO_OFS_OUTCLR   8'h18
`define GPIO_OFS_OUTTGL   8'h1c
`define GPIO_OFS_IN       8'h20
`define GPIO_OFS_INTMSK0  8'h24
`define GPIO_OFS_INTMSK1  8'h28
`define GPIO_OFS_INTFLG   8'h2c
`define GPIO_OFS_MPCSEL   8'h30
`define GPIO_OFS_PINCFG0  8'h40
`define GPIO_OFS_ROUTE    8'h60
`define GPIO_OFS_VPSEL    8'h64

// ----------------------------------------------------------------
// pin configuration word fields
// ----------------------------------------------------------------
`define GPIO_CFG_SENSE_LSB 0
`define GPIO_CFG_DRV_LSB   3
`define GPIO_CFG_INV_BIT   6
`define GPIO_CFG_SLEW_BIT  7
`define GPIO_CFG_RESET     8'h00

// ----------------------------------------------------------------
// route fields and routed pin numbers
// ----------------------------------------------------------------
`define GPIO_ROUTE_CLK_BIT 0
`define GPIO_ROUTE_EV7_BIT 1
`define GPIO_CLK_PIN       3'h7
`define GPIO_EV7_PIN       3'h6

`endif

// file: gpio_pkg.sv
package gpio_pkg;
  // input sense selection
  typedef enum logic [2:0] {
    GPIO_SENSE_BOTH    = 3'h0,
    GPIO_SENSE_RISE    = 3'h1,
    GPIO_SENSE_FALL    = 3'h2,
    GPIO_SENSE_OFF     = 3'h3,
    GPIO_SENSE_LOW     = 3'h4
  } gpio_sense_t;

  // output driver / pull selection
  typedef enum logic [2:0] {
    GPIO_DRV_TOTEM     = 3'h0,
    GPIO_DRV_KEEPER    = 3'h1,
    GPIO_DRV_PULLDN    = 3'h2,
    GPIO_DRV_PULLUP    = 3'h3,
    GPIO_DRV_WOR       = 3'h4,
    GPIO_DRV_WAND      = 3'h5,
    GPIO_DRV_WOR_PD    = 3'h6,
    GPIO_DRV_WAND_PU   = 3'h7
  } gpio_drv_t;
endpackage

// file: gpio_port.sv
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "gpio_consts.svh"

module gpio_port #(
  parameter int NPINS = 8
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // axi4-lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // axi4-lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // pads: value in, drive value, strong enable, weak pull
  input  wire logic [NPINS-1:0] pad_in,
  output logic      [NPINS-1:0] pad_out,
  output logic      [NPINS-1:0] pad_oe,
  output logic      [NPINS-1:0] pad_pull_en,
  output logic      [NPINS-1:0] pad_pull_up,
  output logic      [NPINS-1:0] pad_slew,
  // alternate functions from peripherals
  input  wire logic [NPINS-1:0] alt_en,
  input  wire logic [NPINS-1:0] alt_out,
  input  wire logic [NPINS-1:0] alt_oe,
  output logic      [NPINS-1:0] alt_in,
  // clock and event routing
  input  wire logic             periph_clk_out,
  input  wire logic             event_ch7,
  input  wire logic             port_clk_on,
  // interrupts, events, wake-up
  output logic                  irq0,
  output logic                  irq1,
  output logic      [NPINS-1:0] pin_event,
  output logic                  wake_async,
  // virtual port view
  output logic      [NPINS-1:0] vport_dir,
  output logic      [NPINS-1:0] vport_out,
  output logic      [NPINS-1:0] vport_in,
  output logic      [NPINS-1:0] vport_flags
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [NPINS-1:0] dir_r;
  logic [NPINS-1:0] out_r;
  logic [NPINS-1:0] msk0_r;
  logic [NPINS-1:0] msk1_r;
  logic [NPINS-1:0] flg0_r;
  logic [NPINS-1:0] flg1_r;
  logic [NPINS-1:0] mpc_r;
  logic [7:0]       cfg_r [NPINS];
  logic [1:0]       route_r;
  logic             vp_r;
  logic [NPINS-1:0] sync1_r;
  logic [NPINS-1:0] sync2_r;
  logic [NPINS-1:0] prev_r;
  logic [NPINS-1:0] keep_r;
  logic [NPINS-1:0] inv;
  logic [NPINS-1:0] pin_val;
  logic [NPINS-1:0] hit;
  logic [NPINS-1:0] hit_async;
  logic [NPINS-1:0] drv_val;
  logic [NPINS-1:0] drv_oe;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // sense evaluation of one pin given current and previous value
  function automatic logic sense_hit(input logic [7:0] cfg, input logic cur, input logic prv);
    gpio_pkg::gpio_sense_t s;
    s = gpio_pkg::gpio_sense_t'(cfg[`GPIO_CFG_SENSE_LSB +: 3]);
    case (s)
      gpio_pkg::GPIO_SENSE_BOTH: sense_hit = cur ^ prv;
      gpio_pkg::GPIO_SENSE_RISE: sense_hit = cur & ~prv;
      gpio_pkg::GPIO_SENSE_FALL: sense_hit = ~cur & prv;
      gpio_pkg::GPIO_SENSE_LOW:  sense_hit = ~cur;
      default:                   sense_hit = 1'b0;
    endcase
  endfunction

  // apply a set/clear/toggle style write
  function automatic logic [NPINS-1:0] sct(input logic [NPINS-1:0] v, input logic [NPINS-1:0] d,
                                           input logic [1:0] op);
    case (op)
      2'h1:    sct = v | d;
      2'h2:    sct = v & ~d;
      2'h3:    sct = v ^ d;
      default: sct = d;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic       aw_have_r;
  logic       w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic       w_lane0_r;
  logic       wr_go;
  logic       wr_ok;
  logic [7:0] wa;
  logic [NPINS-1:0] wd;

  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
  assign wr_go         = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wa            = aw_addr_r;
  assign wd            = w_data_r[NPINS-1:0];

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_lane0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // decode writable addresses
  always_comb begin
    wr_ok = 1'b1;
    if (wa >= `GPIO_OFS_PINCFG0 && wa < `GPIO_OFS_PINCFG0 + 8'(4*NPINS)) wr_ok = 1'b1;
    else case (wa)
      `GPIO_OFS_DIR, `GPIO_OFS_DIRSET, `GPIO_OFS_DIRCLR, `GPIO_OFS_DIRTGL,
      `GPIO_OFS_OUT, `GPIO_OFS_OUTSET, `GPIO_OFS_OUTCLR, `GPIO_OFS_OUTTGL,
      `GPIO_OFS_IN, `GPIO_OFS_INTMSK0, `GPIO_OFS_INTMSK1, `GPIO_OFS_INTFLG,
      `GPIO_OFS_MPCSEL, `GPIO_OFS_ROUTE, `GPIO_OFS_VPSEL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic wen;
  assign wen = wr_go & w_lane0_r;

  // direction and output with set/clear/toggle companions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_r <= '0;
      out_r <= '0;
    end else if (wen) begin
      if (wa >= `GPIO_OFS_DIR && wa <= `GPIO_OFS_DIRTGL)
        dir_r <= sct(dir_r, wd, wa[3:2]);
      if (wa >= `GPIO_OFS_OUT && wa <= `GPIO_OFS_OUTTGL)
        out_r <= sct(out_r, wd, wa[3:2]);
    end
  end

  // masks, multi-pin select, routing, virtual port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msk0_r  <= '0;
      msk1_r  <= '0;
      mpc_r   <= '0;
      route_r <= 2'h0;
      vp_r    <= 1'b0;
    end else if (wen) begin
      if (wa == `GPIO_OFS_INTMSK0) msk0_r <= wd;
      if (wa == `GPIO_OFS_INTMSK1) msk1_r <= wd;
      if (wa == `GPIO_OFS_MPCSEL)  mpc_r  <= wd;
      if (wa == `GPIO_OFS_ROUTE)   route_r <= w_data_r[1:0];
      if (wa == `GPIO_OFS_VPSEL)   vp_r   <= w_data_r[0];
    end
  end

  // per-pin configuration; a write to any pin slot also updates every pin set in the multi-pin selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NPINS; i++) cfg_r[i] <= `GPIO_CFG_RESET;
    end else if (wen && wa >= `GPIO_OFS_PINCFG0 && wa < `GPIO_OFS_PINCFG0 + 8'(4*NPINS)) begin
      for (int i = 0; i < NPINS; i++) begin
        if (wa[4:2] == 3'(i) || mpc_r[i]) cfg_r[i] <= w_data_r[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // input path and sensing
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NPINS; i++) inv[i] = cfg_r[i][`GPIO_CFG_INV_BIT];
  end

  // two-stage synchroniser, then previous-sample register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
      prev_r  <= pin_val;
    end
  end

  assign pin_val = sync2_r ^ inv;
  assign alt_in  = pin_val;

  // per-pin sense results, synchronous and asynchronous paths
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      hit[i]       = sense_hit(cfg_r[i], pin_val[i], prev_r[i]);
      hit_async[i] = sense_hit(cfg_r[i], pad_in[i] ^ inv[i], prev_r[i]);
    end
  end

  assign pin_event  = hit;
  assign wake_async = ~port_clk_on & |(hit_async & (msk0_r | msk1_r));

  // sticky interrupt flags; set wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flg0_r <= '0;
      flg1_r <= '0;
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        if (hit[i] && msk0_r[i]) flg0_r[i] <= 1'b1;
        else if (wen && wa == `GPIO_OFS_INTFLG && wd[i]) flg0_r[i] <= 1'b0;
        if (hit[i] && msk1_r[i]) flg1_r[i] <= 1'b1;
        else if (wen && wa == `GPIO_OFS_INTFLG && w_data_r[8+i]) flg1_r[i] <= 1'b0;
      end
    end
  end

  assign irq0 = |flg0_r;
  assign irq1 = |flg1_r;

  // ----------------------------------------------------------------
  // output path
  // ----------------------------------------------------------------
  // value and enable before driver mode, with alternate and routed sources
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      drv_val[i] = out_r[i];
      drv_oe[i]  = dir_r[i];
      if (alt_en[i]) begin
        drv_val[i] = alt_out[i];
        drv_oe[i]  = alt_oe[i];
      end
      if (route_r[`GPIO_ROUTE_CLK_BIT] && 3'(i) == `GPIO_CLK_PIN) begin
        drv_val[i] = periph_clk_out;
        drv_oe[i]  = 1'b1;
      end
      if (route_r[`GPIO_ROUTE_EV7_BIT] && 3'(i) == `GPIO_EV7_PIN) begin
        drv_val[i] = event_ch7;
        drv_oe[i]  = 1'b1;
      end
      drv_val[i] = drv_val[i] ^ inv[i];
    end
  end

  // bus keeper remembers last pad level
  always_ff @(posedge aclk) begin
    if (!aresetn) keep_r <= '0;
    else          keep_r <= sync2_r;
  end

  // driver modes
  always_comb begin
    gpio_pkg::gpio_drv_t m;
    m = gpio_pkg::GPIO_DRV_TOTEM;
    for (int i = 0; i < NPINS; i++) begin
      m = gpio_pkg::gpio_drv_t'(cfg_r[i][`GPIO_CFG_DRV_LSB +: 3]);
      pad_out[i]     = drv_val[i];
      pad_oe[i]      = drv_oe[i];
      pad_pull_en[i] = 1'b0;
      pad_pull_up[i] = 1'b0;
      pad_slew[i]    = cfg_r[i][`GPIO_CFG_SLEW_BIT];
      case (m)
        gpio_pkg::GPIO_DRV_TOTEM: ;
        gpio_pkg::GPIO_DRV_KEEPER: begin
          pad_pull_en[i] = ~drv_oe[i];
          pad_pull_up[i] = keep_r[i];
        end
        gpio_pkg::GPIO_DRV_PULLDN: pad_pull_en[i] = ~drv_oe[i];
        gpio_pkg::GPIO_DRV_PULLUP: begin
          pad_pull_en[i] = ~drv_oe[i];
          pad_pull_up[i] = 1'b1;
        end
        gpio_pkg::GPIO_DRV_WOR: pad_oe[i] = drv_oe[i] & drv_val[i];
        gpio_pkg::GPIO_DRV_WAND: pad_oe[i] = drv_oe[i] & ~drv_val[i];
        gpio_pkg::GPIO_DRV_WOR_PD: begin
          pad_oe[i]      = drv_oe[i] & drv_val[i];
          pad_pull_en[i] = 1'b1;
        end
        gpio_pkg::GPIO_DRV_WAND_PU: begin
          pad_oe[i]      = drv_oe[i] & ~drv_val[i];
          pad_pull_en[i] = 1'b1;
          pad_pull_up[i] = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // virtual port and read path
  // ----------------------------------------------------------------
  assign vport_dir   = vp_r ? dir_r : '0;
  assign vport_out   = vp_r ? out_r : '0;
  assign vport_in    = vp_r ? pin_val : '0;
  assign vport_flags = vp_r ? (flg0_r | flg1_r) : '0;

  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    if (s_axi_araddr >= `GPIO_OFS_PINCFG0 && s_axi_araddr < `GPIO_OFS_PINCFG0 + 8'(4*NPINS))
      rd[7:0] = cfg_r[s_axi_araddr[4:2]];
    else case ({s_axi_araddr[7:2], 2'b00})
      `GPIO_OFS_DIR:     rd[NPINS-1:0] = dir_r;
      `GPIO_OFS_OUT:     rd[NPINS-1:0] = out_r;
      `GPIO_OFS_IN:      rd[NPINS-1:0] = pin_val;
      `GPIO_OFS_INTMSK0: rd[NPINS-1:0] = msk0_r;
      `GPIO_OFS_INTMSK1: rd[NPINS-1:0] = msk1_r;
      `GPIO_OFS_INTFLG:  rd[15:0] = {flg1_r, flg0_r};
      `GPIO_OFS_MPCSEL:  rd[NPINS-1:0] = mpc_r;
      `GPIO_OFS_ROUTE:   rd[1:0] = route_r;
      `GPIO_OFS_VPSEL:   rd[0] = vp_r;
      default:           rd = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_flag_set_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    (|(hit & msk0_r)) |=> irq0) else $error("irq0 not raised");
  a_dir_set_op: assert property (@(posedge aclk) disable iff (!aresetn)
    (wen && wa == `GPIO_OFS_DIRSET) |=> ((dir_r & $past(wd)) == $past(wd))) else $error("dirset failed");
  a_out_tgl_op: assert property (@(posedge aclk) disable iff (!aresetn)
    (wen && wa == `GPIO_OFS_OUTTGL) |=> (out_r == ($past(out_r) ^ $past(wd)))) else $error("outtgl failed");
  a_in_inv_path: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 2) |-> (pin_val == ($past(pad_in, 2) ^ inv))) else $error("input inversion wrong");
  a_out_inv_totem: assert property (@(posedge aclk) disable iff (!aresetn)
    (!alt_en[0] && route_r == 2'h0 && cfg_r[0][5:3] == 3'h0) |-> (pad_out[0] == (out_r[0] ^ inv[0])))
    else $error("output inversion wrong");
  a_edge_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_r[1][2:0] == 3'h1 && pin_val[1] && !prev_r[1]) |-> pin_event[1]) else $error("rise missed");
  a_irq_off_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    (msk1_r == '0 && flg1_r == '0) |=> !irq1) else $error("irq1 without source");
  a_wake_clkon: assert property (@(posedge aclk) disable iff (!aresetn)
    port_clk_on |-> !wake_async) else $error("async wake with clock on");
  a_wand_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg_r[4][5:3] == 3'h5 && drv_val[4]) |-> !pad_oe[4]) else $error("wired-and drove high");

endmodule

// file: gpio_pad_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// outside world at the pins
// ----------------------------------------
module gpio_pad_model (
  // clock for the floating-pin drift
  input  wire logic       aclk,
  // port pad outputs
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pull_en,
  input  wire logic [7:0] pad_pull_up,
  // outside driver per pin
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // resolved pin level
  output logic      [7:0] pad_in
);
  logic [7:0] last_r = 8'h00;

  // strong drive, then outside drive, then weak pull; a bare pin drifts
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_en[i]) pad_in[i] = pad_pull_up[i];
      else pad_in[i] = ~last_r[i];
    end
  end

  // a floating pin changes every cycle so no stale level is trusted
  always @(posedge aclk) begin
    last_r <= pad_in;
  end
endmodule

// file: gpio_port_tb.sv
`timescale 1ns/1ps
`include "gpio_consts.svh"

module gpio_port_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  // clock, reset, counters
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cycles = 0;
  // bus master side
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  // pins, peripherals, routing
  logic [7:0]  pad_in, pad_out, pad_oe, pad_pull_en, pad_pull_up, alt_in, pin_event, vport_out;
  logic [7:0]  pad_slew, vport_dir, vport_flags;
  logic [7:0]  alt_en = 8'h00, alt_out = 8'h00, alt_oe = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic        periph_clk_out = 1'b0, event_ch7 = 1'b0, port_clk_on = 1'b1;
  logic        irq0, irq1, wake_async;

  // 250 MHz clock
  always #2 aclk = ~aclk;

  // ----------------------------------------
  // design and pin model
  // ----------------------------------------
  gpio_port #(.NPINS(8)) u_gpio_port (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .pad_slew(pad_slew), .alt_en(alt_en), .alt_out(alt_out),
    .alt_oe(alt_oe), .alt_in(alt_in), .periph_clk_out(periph_clk_out), .event_ch7(event_ch7),
    .port_clk_on(port_clk_on), .irq0(irq0), .irq1(irq1), .pin_event(pin_event),
    .wake_async(wake_async), .vport_dir(vport_dir), .vport_out(vport_out), .vport_in(),
    .vport_flags(vport_flags)
  );

  gpio_pad_model u_gpio_pad_model (
    .aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
  );

  // ----------------------------------------
  // bus cycles and compare
  // ----------------------------------------
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    {aw, w} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(aw && w)) begin
      @(negedge aclk);
      aw |= s_axi_awvalid && s_axi_awready === 1'b1;
      w |= s_axi_wvalid && s_axi_wready === 1'b1;
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid} <= {!aw, !w};
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // pin configuration word: invert, drive, sense
  function automatic logic [31:0] cfg(input logic [2:0] s, input logic [2:0] dv, input logic inv);
    return {25'h0, inv, dv, s};
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // set, clear and toggle paths, unmapped place
  task automatic t_setclr;
    rdc(8'hf0, 32'h0);
    chk(resp, 2'b00);
    wr(8'hf0, 32'hff);
    chk(resp, 2'b10);
    wr(`GPIO_OFS_OUT, 32'h0f);
    wr(`GPIO_OFS_OUTSET, 32'h30);
    wr(`GPIO_OFS_OUTCLR, 32'h03);
    rdc(`GPIO_OFS_OUT, 32'h3c);
    wr(`GPIO_OFS_OUTTGL, 32'hff);
    rdc(`GPIO_OFS_OUT, 32'hc3);
    wr(`GPIO_OFS_DIRSET, 32'h81);
    wr(`GPIO_OFS_DIRTGL, 32'h03);
    wr(`GPIO_OFS_DIRCLR, 32'h80);
    rdc(`GPIO_OFS_DIR, 32'h02);
    @(negedge aclk);
    chk({pad_oe, pad_out[1]}, 9'h005);
    @(posedge aclk);
    wr(`GPIO_OFS_DIR, 32'h0);
    $display("t_setclr done");
  endtask

  // inversion on two pins set by one write, port and peripheral paths
  task automatic t_invert;
    logic [31:0] d;
    wr(`GPIO_OFS_MPCSEL, 32'h05);
    wr(`GPIO_OFS_PINCFG0, cfg(3'h0, 3'h0, 1'b1));
    rdc(`GPIO_OFS_PINCFG0 + 8'h08, 32'h40);
    wr(`GPIO_OFS_DIR, 32'h01);
    wr(`GPIO_OFS_OUT, 32'h01);
    {ext_en, ext_val} <= 16'h0404;
    cyc(4);
    rd(`GPIO_OFS_IN, d);
    chk(d[2], 1'b0);
    @(negedge aclk);
    chk({pad_out[0], alt_in[2]}, 2'b00);
    @(posedge aclk);
    {alt_en, alt_oe} <= 16'h0101;
    @(negedge aclk);
    chk(pad_out[0], 1'b1);
    @(posedge aclk);
    alt_en <= 8'h00;
    wr(`GPIO_OFS_PINCFG0, 32'h0);
    wr(`GPIO_OFS_MPCSEL, 32'h0);
    wr(`GPIO_OFS_DIR, 32'h0);
    ext_en <= 8'h00;
    $display("t_invert done");
  endtask

  // every sense code on pin 1, masks alternating between the two interrupts
  task automatic t_sense;
    logic [2:0]  sn [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1};
    logic [5:0]  inv = 6'b100000;
    logic [5:0]  v0 = 6'b110000;
    logic [5:0]  v1 = 6'b001111;
    logic [5:0]  hit = 6'b110011;
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      wr(`GPIO_OFS_INTMSK0, (i % 2) ? 32'h0 : 32'h02);
      wr(`GPIO_OFS_INTMSK1, (i % 2) ? 32'h02 : 32'h0);
      {ext_en, ext_val} <= {8'h02, 6'h0, v0[i], 1'b0};
      wr(`GPIO_OFS_PINCFG0 + 8'h04, cfg(sn[i], 3'h0, inv[i]));
      cyc(4);
      wr(`GPIO_OFS_INTFLG, 32'hffff);
      ext_val <= {6'h0, v1[i], 1'b0};
      cyc(6);
      rd(`GPIO_OFS_INTFLG, d);
      chk(d, hit[i] ? ((i % 2) ? 32'h200 : 32'h02) : 32'h0);
      @(negedge aclk);
      chk({irq1, irq0}, hit[i] ? ((i % 2) ? 2'b10 : 2'b01) : 2'b00);
      @(posedge aclk);
    end
    $display("t_sense done");
  endtask

  // weak pulls and the keeper that follows the last level
  task automatic t_pulls;
    wr(`GPIO_OFS_PINCFG0 + 8'h0c, 32'h9b);
    @(negedge aclk);
    chk({pad_pull_en[3], pad_pull_up[3], pad_slew[3]}, 3'b111);
    @(posedge aclk);
    wr(`GPIO_OFS_PINCFG0 + 8'h0c, cfg(3'h3, 3'h1, 1'b0));
    for (int v = 1; v >= 0; v--) begin
      {ext_en, ext_val} <= {8'h08, 4'h0, v[0], 3'h0};
      cyc(4);
      ext_en <= 8'h00;
      cyc(4);
      @(negedge aclk);
      chk({pad_pull_en[3], pad_pull_up[3]}, {1'b1, v[0]});
      @(posedge aclk);
    end
    // wired-and releases a high and drives a low; wired-or with pull-down
    wr(`GPIO_OFS_PINCFG0 + 8'h10, cfg(3'h3, 3'h5, 1'b0));
    wr(`GPIO_OFS_DIRSET, 32'h10);
    wr(`GPIO_OFS_OUT, 32'h10);
    @(negedge aclk);
    chk(pad_oe[4], 1'b0);
    @(posedge aclk);
    wr(`GPIO_OFS_OUT, 32'h00);
    @(negedge aclk);
    chk({pad_oe[4], pad_out[4]}, 2'b10);
    @(posedge aclk);
    wr(`GPIO_OFS_PINCFG0 + 8'h10, cfg(3'h3, 3'h6, 1'b0));
    @(negedge aclk);
    chk({pad_oe[4], pad_pull_en[4], pad_pull_up[4]}, 3'b010);
    @(posedge aclk);
    wr(`GPIO_OFS_DIR, 32'h0);
    $display("t_pulls done");
  endtask

  // clock and event routing, virtual view, wake-up with clock off
  task automatic t_route;
    wr(`GPIO_OFS_ROUTE, 32'h03);
    wr(`GPIO_OFS_VPSEL, 32'h01);
    wr(`GPIO_OFS_OUT, 32'ha5);
    {periph_clk_out, event_ch7} <= 2'b01;
    @(negedge aclk);
    chk({pad_out[7:6], vport_out}, 10'h1a5);
    chk({vport_dir, vport_flags}, 16'h0002);
    @(posedge aclk);
    // low-level sense on pin 1 so the wake does not hang on the previous sample
    wr(`GPIO_OFS_PINCFG0 + 8'h04, cfg(3'h4, 3'h0, 1'b0));
    {port_clk_on, ext_en, ext_val} <= 17'h00200;
    @(negedge aclk);
    chk(wake_async, 1'b1);
    @(posedge aclk);
    port_clk_on <= 1'b1;
    cyc(3);
    @(negedge aclk);
    chk({wake_async, pin_event[1]}, 2'b01);
    @(posedge aclk);
    $display("t_route done");
  endtask

  // ----------------------------------------
  // verdict, timeout and main sequence
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // cut a hang short
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    t_setclr();
    t_invert();
    t_sense();
    t_pulls();
    t_route();
    print_verdict();
  end
endmodule
